/* File: logic/sfrs_pkg.sv */
// Constants and types shared by the serial flash read and status front-end
package sfrs_pkg;
  // Opcodes
  localparam logic [7:0] SFRS_OP_READ = 8'h03;
  localparam logic [7:0] SFRS_OP_READ_FAST = 8'h0b;
  localparam logic [7:0] SFRS_OP_STAT_RD = 8'h05;
  localparam logic [7:0] SFRS_OP_STAT_WR = 8'h01;
  // Last bit index of each serial field
  localparam logic [4:0] SFRS_BYTE_LAST = 5'h07;
  localparam logic [4:0] SFRS_ADDR_LAST = 5'h17;
  localparam logic [4:0] SFRS_DUMMY_LAST = 5'h07;
  // Array geometry
  localparam int unsigned SFRS_ARRAY_AW = 18;
  localparam int unsigned SFRS_ARRAY_BYTES = 262144;
  localparam logic [17:0] SFRS_ARRAY_TOP = 18'h3ffff;
  // Status byte field positions
  localparam int unsigned SFRS_BUSY_BIT = 0;
  localparam int unsigned SFRS_WEL_BIT = 1;
  localparam int unsigned SFRS_BP_LO_BIT = 2;
  localparam int unsigned SFRS_BP_HI_BIT = 3;
  localparam int unsigned SFRS_LOCK_BIT = 7;
  // Reset values; nonvolatile cells come up erased
  localparam logic [1:0] SFRS_BP_RESET = 2'h0;
  localparam logic SFRS_LOCK_RESET = 1'h0;
  localparam logic SFRS_WEL_RESET = 1'h0;
  // Timing
  localparam int unsigned SFRS_CLK_PERIOD_NS = 50;
  localparam int unsigned SFRS_STWR_TIME_NS = 10000000;
  localparam int unsigned SFRS_STWR_CYCLES = SFRS_STWR_TIME_NS / SFRS_CLK_PERIOD_NS;
  // Prefetch buffer
  localparam int unsigned SFRS_FIFO_WIDTH = 8;
  localparam int unsigned SFRS_FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    SFRS_CMD, SFRS_ADDR, SFRS_DUMMY, SFRS_READ, SFRS_STAT_RD,
    SFRS_STWR_DATA, SFRS_STWR_FULL, SFRS_IGNORE
  } sfrs_state_t;
endpackage

/* File: logic/sfrs_fifo.sv */
// Prefetch FIFO with valid/ready on both sides and synchronous clear
`timescale 1ns/1ps
module sfrs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } sfrs_fifo_state_t;

  sfrs_fifo_state_t r;
  sfrs_fifo_state_t next_r;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic push;
  logic pop;

  assign in_ready = r.count != (AW+1)'(DEPTH);
  assign out_valid = r.count != '0;
  assign out_data = store[r.rd_ptr];
  assign push = in_valid & in_ready & ~clear;
  assign pop = out_valid & out_ready & ~clear;

  always_comb begin
    next_r = r;
    if (clear) begin
      next_r = '0;
    end else begin
      if (push) begin
        next_r.wr_ptr = r.wr_ptr + 1'b1;
      end
      if (pop) begin
        next_r.rd_ptr = r.rd_ptr + 1'b1;
      end
      next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Storage needs no reset; only the pointers and count say what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      store[r.wr_ptr] <= in_data;
    end
  end
endmodule // sfrs_fifo

/* File: logic/sfrs_flash.sv */
// Serial flash command front-end: array reads and status byte
`timescale 1ns/1ps
module sfrs_flash
  import sfrs_pkg::*;
#(
  parameter int unsigned STWR_CYCLES = SFRS_STWR_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic wp_n,
  // Enable latch and busy from the write command logic
  input wire logic wel_set,
  input wire logic wel_clear,
  input wire logic ext_busy,
  // Array loading port
  input wire logic mem_load,
  input wire logic [17:0] mem_load_addr,
  input wire logic [7:0] mem_load_data,
  // Status observation
  output logic [7:0] device_status_byte
);
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic si_m;
    logic si_s;
    logic wp_m;
    logic wp_s;
    sfrs_state_t st;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic fast;
    logic [17:0] addr;
    logic fetching;
    logic flush;
    logic [7:0] out_byte;
    logic [2:0] out_cnt;
    logic so;
    logic so_oe;
    logic wel;
    logic [1:0] bp;
    logic lock;
    logic wr_busy;
    logic [17:0] wr_cnt;
    logic [7:0] wr_data;
    logic [7:0] status;
  } sfrs_regs_t;

  sfrs_regs_t r;
  sfrs_regs_t next_r;
  logic [7:0] mem [0:SFRS_ARRAY_BYTES-1];
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic push_fire;
  logic wr_done;
  logic wr_allowed;
  logic [7:0] status_now;
  logic [23:0] sh;

  localparam logic [17:0] STWR_LAST = 18'(STWR_CYCLES - 1);

  assign sck_rise = r.sck_s & ~r.sck_d;
  assign sck_fall = ~r.sck_s & r.sck_d;
  assign cs_rise = r.cs_s & ~r.cs_d;
  assign sh = {r.shift[22:0], r.si_s};
  assign fifo_in_valid = r.fetching & ~r.flush;
  assign push_fire = fifo_in_valid & fifo_in_ready;
  assign wr_done = r.wr_busy && r.wr_cnt == STWR_LAST;
  // Locked status needs the protect pin high to be rewritten
  assign wr_allowed = r.wel & ~r.wr_busy & ~(r.lock & ~r.wp_s);

  always_comb begin
    status_now = '0;
    status_now[SFRS_BUSY_BIT] = r.wr_busy | ext_busy;
    status_now[SFRS_WEL_BIT] = r.wel;
    status_now[SFRS_BP_LO_BIT] = r.bp[0];
    status_now[SFRS_BP_HI_BIT] = r.bp[1];
    status_now[SFRS_LOCK_BIT] = r.lock;
  end

  always_comb begin
    next_r = r;
    fifo_out_ready = 1'b0;
    next_r.cs_m = cs_n;
    next_r.cs_s = r.cs_m;
    next_r.cs_d = r.cs_s;
    next_r.sck_m = sck;
    next_r.sck_s = r.sck_m;
    next_r.sck_d = r.sck_s;
    next_r.si_m = si;
    next_r.si_s = r.si_m;
    next_r.wp_m = wp_n;
    next_r.wp_s = r.wp_m;
    next_r.flush = 1'b0;
    next_r.status = status_now;
    if (push_fire) begin
      next_r.addr = r.addr + 18'h1;
    end
    if (wel_clear) begin
      next_r.wel = 1'b0;
    end
    if (wel_set) begin
      next_r.wel = 1'b1;
    end
    // Internal nonvolatile update of the status bits
    if (r.wr_busy) begin
      if (wr_done) begin
        next_r.wr_busy = 1'b0;
        next_r.bp = {r.wr_data[SFRS_BP_HI_BIT], r.wr_data[SFRS_BP_LO_BIT]};
        next_r.lock = r.wr_data[SFRS_LOCK_BIT];
        next_r.wel = 1'b0;
      end else begin
        next_r.wr_cnt = r.wr_cnt + 18'h1;
      end
    end
    if (r.cs_s) begin
      next_r.st = SFRS_CMD;
      next_r.so_oe = 1'b0;
      next_r.fetching = 1'b0;
      next_r.bit_cnt = '0;
      next_r.out_cnt = '0;
      if (cs_rise) begin
        next_r.flush = 1'b1;
        // Only a full opcode plus data byte reaches this state
        if (r.st == SFRS_STWR_FULL && wr_allowed) begin
          next_r.wr_busy = 1'b1;
          next_r.wr_cnt = '0;
        end
      end
    end else begin
      if (sck_rise) begin
        next_r.shift = sh;
        next_r.bit_cnt = r.bit_cnt + 5'h01;
        unique case (r.st)
          SFRS_CMD: begin
            if (r.bit_cnt == SFRS_BYTE_LAST) begin
              next_r.bit_cnt = '0;
              next_r.fast = sh[7:0] == SFRS_OP_READ_FAST;
              if (sh[7:0] == SFRS_OP_READ || sh[7:0] == SFRS_OP_READ_FAST) begin
                next_r.st = SFRS_ADDR;
              end else if (sh[7:0] == SFRS_OP_STAT_RD) begin
                next_r.st = SFRS_STAT_RD;
                next_r.out_cnt = 3'h7;
              end else if (sh[7:0] == SFRS_OP_STAT_WR) begin
                next_r.st = SFRS_STWR_DATA;
              end else begin
                next_r.st = SFRS_IGNORE;
              end
            end
          end
          SFRS_ADDR: begin
            if (r.bit_cnt == SFRS_ADDR_LAST) begin
              // Upper address bits beyond the array are ignored
              next_r.addr = sh[SFRS_ARRAY_AW-1:0];
              next_r.bit_cnt = '0;
              next_r.out_cnt = '0;
              if (r.fast) begin
                next_r.st = SFRS_DUMMY;
              end else begin
                next_r.st = SFRS_READ;
                next_r.flush = 1'b1;
                next_r.fetching = 1'b1;
              end
            end
          end
          SFRS_DUMMY: begin
            if (r.bit_cnt == SFRS_DUMMY_LAST) begin
              next_r.st = SFRS_READ;
              next_r.flush = 1'b1;
              next_r.fetching = 1'b1;
            end
          end
          SFRS_STWR_DATA: begin
            if (r.bit_cnt == SFRS_BYTE_LAST) begin
              next_r.wr_data = sh[7:0];
              next_r.st = SFRS_STWR_FULL;
            end
          end
          // An overlong status write is not a complete sequence
          SFRS_STWR_FULL: next_r.st = SFRS_IGNORE;
          SFRS_READ, SFRS_STAT_RD, SFRS_IGNORE: begin
          end
        endcase
      end
      if (sck_fall) begin
        if (r.st == SFRS_READ) begin
          next_r.so_oe = 1'b1;
          if (r.out_cnt == 3'h0) begin
            fifo_out_ready = 1'b1;
            next_r.so = fifo_out_data[7];
            next_r.out_byte = {fifo_out_data[6:0], 1'b0};
            next_r.out_cnt = 3'h7;
          end else begin
            next_r.so = r.out_byte[7];
            next_r.out_byte = {r.out_byte[6:0], 1'b0};
            next_r.out_cnt = r.out_cnt - 3'h1;
          end
        end else if (r.st == SFRS_STAT_RD) begin
          next_r.so_oe = 1'b1;
          next_r.so = status_now[r.out_cnt];
          next_r.out_cnt = r.out_cnt - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.cs_m <= 1'b1;
      r.cs_s <= 1'b1;
      r.cs_d <= 1'b1;
      r.wp_m <= 1'b1;
      r.wp_s <= 1'b1;
      r.st <= SFRS_CMD;
      r.wel <= SFRS_WEL_RESET;
      r.bp <= SFRS_BP_RESET;
      r.lock <= SFRS_LOCK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Array storage; reads are prefetched so the link never waits
  always_ff @(posedge clk) begin
    if (mem_load) begin
      mem[mem_load_addr] <= mem_load_data;
    end
  end

  sfrs_fifo #(
    .WIDTH(SFRS_FIFO_WIDTH),
    .DEPTH(SFRS_FIFO_DEPTH)
  ) u_prefetch (
    .clk(clk),
    .reset_n(reset_n),
    .clear(r.flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(mem[r.addr]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign so = r.so;
  assign so_oe = r.so_oe;
  assign device_status_byte = r.status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  deselect_hiz_a: assert property (r.cs_s |=> !r.so_oe)
    else $error("output enabled while deselected");
  read_start_a: assert property (r.st == SFRS_ADDR && sck_rise && !r.cs_s &&
      r.bit_cnt == SFRS_ADDR_LAST && !r.fast |=> r.st == SFRS_READ && r.flush)
    else $error("normal read did not start after address");
  fast_dummy_a: assert property (r.st == SFRS_DUMMY && sck_rise && !r.cs_s &&
      r.bit_cnt == SFRS_DUMMY_LAST |=> r.st == SFRS_READ)
    else $error("fast read did not start after dummy bits");
  addr_incr_a: assert property (push_fire && r.addr != SFRS_ARRAY_TOP && !cs_rise
      |=> r.addr == $past(r.addr) + 18'h1)
    else $error("read address did not advance");
  addr_wrap_a: assert property (push_fire && r.addr == SFRS_ARRAY_TOP |=> r.addr == '0)
    else $error("read address did not wrap");
  stat_start_a: assert property (r.st == SFRS_CMD && sck_rise && !r.cs_s &&
      r.bit_cnt == SFRS_BYTE_LAST && sh[7:0] == SFRS_OP_STAT_RD
      |=> r.st == SFRS_STAT_RD && r.out_cnt == 3'h7)
    else $error("status read did not start at lock bit");
  stat_repeat_a: assert property (r.st == SFRS_STAT_RD && sck_fall && !r.cs_s &&
      r.out_cnt == 3'h0 |=> r.out_cnt == 3'h7 && r.so == $past(status_now[0]))
    else $error("status byte did not restart");
  lock_ignore_a: assert property (cs_rise && r.st == SFRS_STWR_FULL && !r.wr_busy &&
      r.lock && !r.wp_s |=> !r.wr_busy)
    else $error("locked status write was started");
  busy_hold_a: assert property (r.wr_busy && !wr_done |=> r.wr_busy &&
      r.status[SFRS_BUSY_BIT] == 1'b1)
    else $error("busy dropped before update end");
  write_end_a: assert property (wr_done |=> !r.wel && r.lock == $past(r.wr_data[7]) &&
      r.bp == $past(r.wr_data[3:2]))
    else $error("status update end wrong");
  reserved_zero_a: assert property (r.status[6:4] == 3'h0)
    else $error("reserved status bits not zero");
  unknown_off_a: assert property (r.st == SFRS_IGNORE |-> !r.so_oe)
    else $error("output driven after unknown opcode");
  // A starved prefetch would put a stale byte on the link
  prefetch_ready_a: assert property (r.st == SFRS_READ && sck_fall && !r.cs_s &&
      r.out_cnt == 3'h0 |-> fifo_out_valid)
    else $error("prefetch empty at byte start");
  read_bit_a: assert property (r.st == SFRS_READ && sck_fall && !r.cs_s &&
      r.out_cnt != 3'h0 |=> r.so_oe && r.so == $past(r.out_byte[7]))
    else $error("read bit out of order");
  stat_bit_a: assert property (r.st == SFRS_STAT_RD && sck_fall && !r.cs_s
      |=> r.so_oe && r.so == $past(status_now[r.out_cnt]))
    else $error("status bit out of order");
  stwr_start_a: assert property (cs_rise && r.st == SFRS_STWR_FULL && wr_allowed
      |=> r.wr_busy && r.wr_cnt == '0)
    else $error("status update did not start");
  short_write_a: assert property (cs_rise && r.st != SFRS_STWR_FULL && !r.wr_busy
      |=> !r.wr_busy)
    else $error("incomplete status write started");
  nv_hold_a: assert property (!wr_done |=> r.bp == $past(r.bp) && r.lock == $past(r.lock))
    else $error("protect or lock changed outside update");

  read_seen_c: cover property (r.st == SFRS_READ && fifo_out_ready && !r.fast);
  fast_seen_c: cover property (r.st == SFRS_READ && fifo_out_ready && r.fast);
  stat_busy_c: cover property (r.st == SFRS_STAT_RD && sck_fall && r.wr_busy);
  stwr_done_c: cover property (wr_done);
endmodule // sfrs_flash

/* File: test/sfrs_host_model.sv */
// Host controller model driving the serial flash link in mode 0
`timescale 1ns/1ps
module sfrs_host_model (
  // Link pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  localparam int HALF_NS = 200;
  logic oe_any;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    oe_any = 1'b0;
  end
  // Offset keeps link edges clear of the system clock edges
  task automatic select();
    #7 cs_n = 1'b0;
    oe_any = 1'b0;
    #HALF_NS;
  endtask
  // Sends nb bits from the top of tx; so is taken just before the next fall
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int b = 7; b > 7 - nb; b--) begin
      si = tx[b];
      #HALF_NS sck = 1'b1;
      #HALF_NS rx[b] = so_oe ? so : 1'bz;
      oe_any = oe_any | so_oe;
      sck = 1'b0;
    end
  endtask
  // Released data line shows a stale inverse, not the last bit
  task automatic deselect();
    #HALF_NS cs_n = 1'b1;
    si = ~si;
    #(4 * HALF_NS);
  endtask
endmodule // sfrs_host_model

/* File: test/tb_sfrs_flash.sv */
// Self-checking bench for the serial flash read and status front-end
`timescale 1ns/1ps
module tb_sfrs_flash;
  import sfrs_pkg::*;
  // Short update time keeps the run brief
  localparam int unsigned STWR = 200;
  logic clk = 1'b0, reset_n = 1'b0, wp_n = 1'b1, ext_busy = 1'b0;
  logic wel_set = 1'b0, wel_clear = 1'b0, mem_load = 1'b0;
  logic [17:0] mem_load_addr = 18'h00000;
  logic [7:0] mem_load_data = 8'h00;
  logic cs_n, sck, si, so, so_oe;
  logic [7:0] status;
  logic [7:0] ref_mem [int];
  int num_errors = 0, num_checks = 0, cyc = 0, seed = 32'h386e996a;
  always #25 clk = ~clk;
  sfrs_flash #(.STWR_CYCLES(STWR)) DUT (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .wel_set(wel_set),
    .wel_clear(wel_clear), .ext_busy(ext_busy), .mem_load(mem_load),
    .mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data),
    .device_status_byte(status));
  sfrs_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  function automatic logic [7:0] stat_after(input logic [7:0] d);
    return {d[7], 3'b000, d[3:2], 2'b00};
  endfunction
  task automatic load(input logic [17:0] a, input logic [7:0] d);
    mem_load_addr <= a;
    mem_load_data <= d;
    mem_load <= 1'b1;
    ref_mem[int'(a)] = d;
    @(posedge clk);
  endtask
  task automatic pulse(input bit set);
    if (set) wel_set <= 1'b1;
    else wel_clear <= 1'b1;
    @(posedge clk);
    wel_set <= 1'b0;
    wel_clear <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [7:0] rx;
    logic [17:0] wa;
    host.select();
    host.xfer(op, 8, rx);
    for (int i = 16; i >= 0; i -= 8) host.xfer(a[i+:8], 8, rx);
    if (op == SFRS_OP_READ_FAST) host.xfer(8'($random(seed)), 8, rx);
    for (int i = 0; i < n; i++) begin
      wa = a[17:0] + 18'(i);
      host.xfer(8'h00, 8, rx);
      chk8("read data", ref_mem[int'(wa)], rx);
    end
    host.deselect();
    @(posedge clk);
    chk1("so_oe after read", 1'b0, so_oe);
  endtask
  task automatic rd_stat(input logic [7:0] exp, input int n);
    logic [7:0] rx;
    host.select();
    host.xfer(SFRS_OP_STAT_RD, 8, rx);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, 8, rx);
      chk8("status read", exp, rx);
    end
    host.deselect();
    @(posedge clk);
  endtask
  task automatic wr_stat(input logic [7:0] d, input int nb);
    logic [7:0] rx;
    host.select();
    host.xfer(SFRS_OP_STAT_WR, 8, rx);
    host.xfer(d, nb > 8 ? 8 : nb, rx);
    if (nb > 8) host.xfer(8'h00, nb - 8, rx);
    host.deselect();
    @(posedge clk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && status[0] !== 1'b0; i++) @(posedge clk);
  endtask
  initial begin
    logic [7:0] d;
    logic [23:0] a;
    logic [7:0] rx;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk8("status reset", 8'h00, status);
    chk1("so_oe reset", 1'b0, so_oe);
    rd_stat(8'h00, 2);
    $display("test reset done");
    // Top of array and its wrap
    for (int i = 0; i < 4; i++) load(18'h3fffe + 18'(i), 8'($random(seed)));
    mem_load <= 1'b0;
    rd(SFRS_OP_READ_FAST, 24'hc3fffe, 4);
    rd(SFRS_OP_READ, 24'h03ffff, 3);
    for (int k = 0; k < 4; k++) begin
      a = 24'($random(seed));
      for (int i = 0; i < 4; i++) load(a[17:0] + 18'(i), 8'($random(seed)));
      mem_load <= 1'b0;
      rd(k[0] ? SFRS_OP_READ_FAST : SFRS_OP_READ, a, 4);
    end
    $display("test array read done");
    host.select();
    host.xfer(8'h5a, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.deselect();
    @(posedge clk);
    chk1("so_oe unknown opcode", 1'b0, host.oe_any);
    d = 8'($random(seed)) | 8'h80;
    wr_stat(d, 8);
    repeat (10) @(posedge clk);
    chk8("write without enable", 8'h00, status);
    pulse(1'b1);
    chk8("enable latch", 8'h02, status);
    wr_stat(d, 4);
    repeat (10) @(posedge clk);
    chk8("short write", 8'h02, status);
    wr_stat(d, 9);
    repeat (10) @(posedge clk);
    chk8("long write", 8'h02, status);
    wr_stat(d, 8);
    rd_stat(8'h03, 1);
    wait_idle();
    repeat (2) @(posedge clk);
    chk8("status written", stat_after(d), status);
    $display("test status write done");
    wp_n <= 1'b0;
    pulse(1'b1);
    wr_stat(8'h00, 8);
    repeat (10) @(posedge clk);
    chk8("locked write", stat_after(d) | 8'h02, status);
    wp_n <= 1'b1;
    wr_stat(8'h00, 8);
    wait_idle();
    repeat (2) @(posedge clk);
    chk8("unlocked write", 8'h00, status);
    $display("test lock done");
    pulse(1'b1);
    pulse(1'b0);
    chk8("enable cleared", 8'h00, status);
    ext_busy <= 1'b1;
    rd_stat(8'h01, 1);
    ext_busy <= 1'b0;
    $display("test busy done");
    give_verdict();
  end
endmodule // tb_sfrs_flash
